// ==== dram_bank_pkg.sv ====
// Constants, command and bank-state types for the bank state tracker.
// Assumes a single 40 MHz core clock; times are turned into whole cycles here.
package dram_bank_pkg;

    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int TMR_W = 8;
    localparam int CLK_PERIOD_NS = 25;

    // Timing figures in ns (plain defaults)
    localparam int T_RP_NS = 18;
    localparam int T_RCD_NS = 18;
    localparam int T_RFCPB_NS = 90;
    localparam int T_RFCAB_NS = 210;
    localparam int T_MRR_NS = 100;
    localparam int T_MRW_NS = 250;
    localparam int T_XP_NS = 8;
    localparam int T_RST_NS = 1000;

    // Least times, rounded up to whole cycles
    localparam int T_RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RCD_CYC = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RFCPB_CYC = (T_RFCPB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RFCAB_CYC = (T_RFCAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_MRR_CYC = (T_MRR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_MRW_CYC = (T_MRW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_XP_CYC = (T_XP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BURST_CYC = 4;
    localparam int AP_CYC = BURST_CYC + T_RP_CYC;

    typedef logic [TMR_W-1:0] tmr_t;

    typedef enum logic [3:0] {
        CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE,
        CMD_REF_PB, CMD_REF_AB, CMD_MRR, CMD_MRW
    } cmd_op_e;

    typedef enum logic [4:0] {
        ST_POWER_ON, ST_RESETTING, ST_IDLE, ST_ACTIVATING, ST_ACTIVE,
        ST_READING, ST_WRITING, ST_RD_AP, ST_WR_AP, ST_PRECHARGING,
        ST_PRE_ALL, ST_REF_PB, ST_REF_AB, ST_MRR_IDLE, ST_MRR_ACTIVE,
        ST_MRR_RESET, ST_MR_WRITING
    } bank_state_e;

    typedef struct packed {
        cmd_op_e op;
        logic [BANK_W-1:0] bank;
        logic auto_precharge;
        logic all_banks_select;
        logic mrw_reset;
    } cmd_s;

    typedef struct packed {
        logic all_banks_idle;
        logic cmd_taken;
        logic cmd_illegal;
    } status_s;

    // Timer load for a state lasting cyc cycles
    function automatic tmr_t cyc_to_tmr(input int cyc);
        return tmr_t'(cyc - 1);
    endfunction : cyc_to_tmr

endpackage : dram_bank_pkg

// ==== bank_timer.sv ====
// Per-bank countdown timer; done is high once the loaded count has run out.
// Assumes load is a one-cycle strobe from the bank state logic.
`timescale 1ns/1ps
module bank_timer
    import dram_bank_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic load,
    input wire tmr_t load_val,
    output logic done
);

    tmr_t cnt_q;
    tmr_t cnt_d;

    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - tmr_t'(1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == '0);

endmodule : bank_timer

// ==== dram_bank_state_tracker.sv ====
// Bank state tracking and command legality for a low-power DDR device.
// Assumes commands arrive already decoded, synchronous to core_clk.
//
// Overview of operation
// - Commands count only with clock enable high on two edges and exit time met.
// - A bank is idle after precharge and full tRP, or when refresh, register read from idle, register write, or reset ends.
// - A bank is active once its row opened and tRCD passed, no burst running.
// - Reading and writing states mean burst without auto precharge; row stays open.
// - Precharge starts precharging; bank idle after tRP.
// - Activate starts row activating; bank active after tRCD.
// - Read or write with auto precharge keeps bank busy until tRP ends, then idle.
// - Per-bank refresh idles after tRFCpb; all-bank refresh idles all after tRFCab.
// - Register read lasts tMRR then returns to idle, active or resetting.
// - Register write lasts tMRW then the bank is idle.
// - Precharge-all holds banks for tRP, then all idle.
// - Device reset is carried by the register write command.
// - Precharge to an idle bank still occupies it for tRP.
// - Other banks take activate, read, write, precharge into matching states.
// - Register read while resetting enters the resetting register-read state.
// - All-banks select during precharge precharges every bank, bank field ignored.
`timescale 1ns/1ps
module dram_bank_state_tracker
    import dram_bank_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic cke,
    input wire cmd_s cmd,
    output bank_state_e bank_state [NUM_BANKS],
    output status_s status
);

    logic cke_q;
    logic cke_d;
    tmr_t xp_cnt_q;
    tmr_t xp_cnt_d;
    logic cmd_ok;
    bank_state_e st_q [NUM_BANKS];
    bank_state_e st_d [NUM_BANKS];
    status_s status_q;
    status_s status_d;
    logic [NUM_BANKS-1:0] tmr_load_en;
    logic [NUM_BANKS-1:0] tmr_done;
    tmr_t tmr_val [NUM_BANKS];
    logic all_idle;
    logic all_power_on;
    logic burst_any;
    logic excl_any;
    logic pre_all_ok;
    logic mrr_ok;
    logic legal;
    logic take;
    logic [BANK_W-1:0] sel;

    // Bank may take a precharge: idle, active, or open row with burst done
    function automatic logic pre_ok(input bank_state_e s, input logic done);
        return (s == ST_IDLE) || (s == ST_ACTIVE)
            || (((s == ST_READING) || (s == ST_WRITING)) && done);
    endfunction : pre_ok

    // Clock enable history and exit-time gate
    always_comb begin
        cke_d = cke;
        xp_cnt_d = xp_cnt_q;
        if (!cke) begin
            xp_cnt_d = tmr_t'(T_XP_CYC);
        end else if (xp_cnt_q != '0) begin
            xp_cnt_d = xp_cnt_q - tmr_t'(1);
        end
        cmd_ok = cke && cke_q && (xp_cnt_q == '0);
    end

    // Per-bank countdowns
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        bank_timer u_timer (
            .core_clk(core_clk),
            .rst(rst),
            .load(tmr_load_en[b]),
            .load_val(tmr_val[b]),
            .done(tmr_done[b])
        );
    end

    // Device-wide summary and legality check
    always_comb begin
        all_idle = 1'b1;
        all_power_on = 1'b1;
        burst_any = 1'b0;
        excl_any = 1'b0;
        pre_all_ok = 1'b1;
        mrr_ok = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (st_q[b] != ST_IDLE) begin
                all_idle = 1'b0;
            end
            if (st_q[b] != ST_POWER_ON) begin
                all_power_on = 1'b0;
            end
            if (!pre_ok(st_q[b], tmr_done[b])) begin
                pre_all_ok = 1'b0;
            end
            if (!(st_q[b] inside {ST_IDLE, ST_ACTIVE, ST_RESETTING, ST_ACTIVATING,
                                  ST_PRECHARGING})) begin
                mrr_ok = 1'b0;
            end
            case (st_q[b])
                ST_READING, ST_WRITING: begin
                    if (!tmr_done[b]) begin
                        burst_any = 1'b1;
                    end
                end
                ST_RD_AP, ST_WR_AP: begin
                    burst_any = 1'b1;
                end
                ST_REF_PB, ST_REF_AB, ST_MRR_IDLE, ST_MRR_ACTIVE, ST_MRR_RESET,
                ST_MR_WRITING, ST_PRE_ALL: begin
                    excl_any = 1'b1;
                end
                default: begin
                end
            endcase
        end
        sel = cmd.bank;
        case (cmd.op)
            CMD_ACT: begin
                legal = (st_q[sel] == ST_IDLE);
            end
            CMD_RD, CMD_WR: begin
                legal = (st_q[sel] inside {ST_ACTIVE, ST_READING, ST_WRITING})
                    && tmr_done[sel];
            end
            CMD_PRE: begin
                legal = cmd.all_banks_select ? pre_all_ok
                    : pre_ok(st_q[sel], tmr_done[sel]);
            end
            CMD_REF_PB: begin
                legal = (st_q[sel] == ST_IDLE) && !burst_any;
            end
            CMD_REF_AB: begin
                legal = all_idle;
            end
            CMD_MRW: begin
                legal = all_idle || (cmd.mrw_reset && all_power_on);
            end
            CMD_MRR: begin
                legal = mrr_ok && !burst_any;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
        if (excl_any) begin
            legal = 1'b0;
        end
        take = cmd_ok && legal && (cmd.op != CMD_NOP);
    end

    // Bank state next values
    always_comb begin
        for (int b = 0; b < NUM_BANKS; b++) begin
            st_d[b] = st_q[b];
            tmr_load_en[b] = 1'b0;
            tmr_val[b] = '0;
            if (tmr_done[b]) begin
                case (st_q[b])
                    ST_ACTIVATING: st_d[b] = ST_ACTIVE;
                    ST_MRR_ACTIVE: st_d[b] = ST_ACTIVE;
                    ST_MRR_IDLE: st_d[b] = ST_IDLE;
                    ST_PRECHARGING: st_d[b] = ST_IDLE;
                    ST_PRE_ALL: st_d[b] = ST_IDLE;
                    ST_RD_AP, ST_WR_AP: st_d[b] = ST_IDLE;
                    ST_REF_PB, ST_REF_AB: st_d[b] = ST_IDLE;
                    ST_MR_WRITING: st_d[b] = ST_IDLE;
                    ST_RESETTING: st_d[b] = ST_IDLE;
                    ST_MRR_RESET: begin
                        st_d[b] = ST_RESETTING;
                        tmr_load_en[b] = 1'b1;
                        tmr_val[b] = cyc_to_tmr(T_RST_CYC);
                    end
                    default: begin
                    end
                endcase
            end
            if (take) begin
                case (cmd.op)
                    CMD_ACT: begin
                        if (BANK_W'(b) == sel) begin
                            st_d[b] = ST_ACTIVATING;
                            tmr_load_en[b] = 1'b1;
                            tmr_val[b] = cyc_to_tmr(T_RCD_CYC);
                        end
                    end
                    CMD_RD, CMD_WR: begin
                        if (BANK_W'(b) == sel) begin
                            tmr_load_en[b] = 1'b1;
                            if (cmd.auto_precharge) begin
                                st_d[b] = (cmd.op == CMD_RD) ? ST_RD_AP : ST_WR_AP;
                                tmr_val[b] = cyc_to_tmr(AP_CYC);
                            end else begin
                                st_d[b] = (cmd.op == CMD_RD) ? ST_READING : ST_WRITING;
                                tmr_val[b] = cyc_to_tmr(BURST_CYC);
                            end
                        end
                    end
                    CMD_PRE: begin
                        if (cmd.all_banks_select) begin
                            st_d[b] = ST_PRE_ALL;
                            tmr_load_en[b] = 1'b1;
                            tmr_val[b] = cyc_to_tmr(T_RP_CYC);
                        end else if (BANK_W'(b) == sel) begin
                            st_d[b] = ST_PRECHARGING;
                            tmr_load_en[b] = 1'b1;
                            tmr_val[b] = cyc_to_tmr(T_RP_CYC);
                        end
                    end
                    CMD_REF_PB: begin
                        if (BANK_W'(b) == sel) begin
                            st_d[b] = ST_REF_PB;
                            tmr_load_en[b] = 1'b1;
                            tmr_val[b] = cyc_to_tmr(T_RFCPB_CYC);
                        end
                    end
                    CMD_REF_AB: begin
                        st_d[b] = ST_REF_AB;
                        tmr_load_en[b] = 1'b1;
                        tmr_val[b] = cyc_to_tmr(T_RFCAB_CYC);
                    end
                    CMD_MRW: begin
                        tmr_load_en[b] = 1'b1;
                        if (cmd.mrw_reset) begin
                            st_d[b] = ST_RESETTING;
                            tmr_val[b] = cyc_to_tmr(T_RST_CYC);
                        end else begin
                            st_d[b] = ST_MR_WRITING;
                            tmr_val[b] = cyc_to_tmr(T_MRW_CYC);
                        end
                    end
                    CMD_MRR: begin
                        // Activating and precharging banks keep their own countdown
                        case (st_q[b])
                            ST_IDLE: st_d[b] = ST_MRR_IDLE;
                            ST_ACTIVE: st_d[b] = ST_MRR_ACTIVE;
                            ST_RESETTING: st_d[b] = ST_MRR_RESET;
                            default: begin
                            end
                        endcase
                        if (st_q[b] inside {ST_IDLE, ST_ACTIVE, ST_RESETTING}) begin
                            tmr_load_en[b] = 1'b1;
                            tmr_val[b] = cyc_to_tmr(T_MRR_CYC);
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
        status_d.all_banks_idle = 1'b1;
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (st_d[b] != ST_IDLE) begin
                status_d.all_banks_idle = 1'b0;
            end
        end
        status_d.cmd_taken = take;
        status_d.cmd_illegal = cmd_ok && !legal && (cmd.op != CMD_NOP);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cke_q <= 1'b0;
            xp_cnt_q <= '0;
            status_q <= '0;
            for (int b = 0; b < NUM_BANKS; b++) begin
                st_q[b] <= ST_POWER_ON;
            end
        end else begin
            cke_q <= cke_d;
            xp_cnt_q <= xp_cnt_d;
            status_q <= status_d;
            for (int b = 0; b < NUM_BANKS; b++) begin
                st_q[b] <= st_d[b];
            end
        end
    end

    assign bank_state = st_q;
    assign status = status_q;

    // Checks
    localparam int RP_D = T_RP_CYC;
    localparam int RCD_D = T_RCD_CYC;
    localparam int AP_D = AP_CYC;
    localparam int BURST_D = BURST_CYC;
    localparam int RFCAB_D = T_RFCAB_CYC;
    localparam int MRW_D = T_MRW_CYC;
    localparam int MRR_D = T_MRR_CYC;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_to_bank0(cmd_op_e op);
        take && (cmd.op == op) && (cmd.bank == '0);
    endsequence

    sequence s_pre0;
        s_to_bank0(CMD_PRE) ##0 !cmd.all_banks_select;
    endsequence

    a_cke_gate: assert property (!cke |=> !status_q.cmd_taken)
        else $error("command taken with clock enable low");
    a_act_open: assert property (s_to_bank0(CMD_ACT) |->
        ##RCD_D (st_q[0] == ST_ACTIVATING) ##1 (st_q[0] == ST_ACTIVE))
        else $error("activate timing wrong");
    a_pre_close: assert property (s_pre0 |->
        ##RP_D (st_q[0] == ST_PRECHARGING) ##1 (st_q[0] == ST_IDLE))
        else $error("precharge timing wrong");
    a_rd_ap_idle: assert property (s_to_bank0(CMD_RD) ##0 cmd.auto_precharge |->
        ##AP_D (st_q[0] == ST_RD_AP) ##1 (st_q[0] == ST_IDLE))
        else $error("auto precharge read timing wrong");
    a_read_open: assert property (s_to_bank0(CMD_RD) ##0 !cmd.auto_precharge |->
        ##BURST_D (st_q[0] == ST_READING) ##1 (st_q[0] == ST_READING))
        else $error("read without auto precharge closed row");
    a_refab_idle: assert property (take && cmd.op == CMD_REF_AB |->
        ##RFCAB_D (st_q[0] == ST_REF_AB) ##1 status_q.all_banks_idle)
        else $error("all-bank refresh timing wrong");
    a_mrw_idle: assert property (take && cmd.op == CMD_MRW && !cmd.mrw_reset |->
        ##MRW_D (st_q[0] == ST_MR_WRITING) ##1 (st_q[0] == ST_IDLE))
        else $error("register write timing wrong");
    a_mrr_back: assert property (take && cmd.op == CMD_MRR && st_q[0] == ST_ACTIVE |->
        ##MRR_D (st_q[0] == ST_MRR_ACTIVE) ##1 (st_q[0] == ST_ACTIVE))
        else $error("register read did not return to active");
    a_mrr_reset: assert property (take && cmd.op == CMD_MRR && st_q[0] == ST_RESETTING
        |=> st_q[0] == ST_MRR_RESET)
        else $error("register read while resetting misrouted");
    a_pre_all: assert property (take && cmd.op == CMD_PRE && cmd.all_banks_select |->
        ##RP_D (st_q[NUM_BANKS-1] == ST_PRE_ALL) ##1 status_q.all_banks_idle)
        else $error("precharge-all timing wrong");
    a_reset_mrw: assert property (take && cmd.op == CMD_MRW && cmd.mrw_reset
        |=> st_q[0] == ST_RESETTING)
        else $error("reset through register write missed");
    a_ap_blocked: assert property (st_q[0] == ST_RD_AP && cmd.bank == '0
        && cmd.op != CMD_NOP && !(cmd.op == CMD_PRE && cmd.all_banks_select)
        |-> !take)
        else $error("command taken by bank in auto precharge burst");

endmodule : dram_bank_state_tracker

// ==== ctrl_model.sv ====
// Memory controller model: drives clock enable and one command at a time.
// Assumes the bench calls its tasks; every change lands on the falling edge.
`timescale 1ns/1ps
module ctrl_model
    import dram_bank_pkg::*;
(
    input wire logic core_clk,
    output logic cke,
    output cmd_s cmd
);
    initial begin
        cke = 1'b1;
        cmd = '{op: CMD_NOP, default: '0};
    end

    task automatic hold_cke(input logic v);
        @(negedge core_clk);
        cke <= v;
    endtask : hold_cke

    // One command for one edge, then no-operation with scrambled fields
    task automatic send(input cmd_op_e op, input logic [BANK_W-1:0] bk, input logic ap,
                        input logic ab, input logic mr);
        @(negedge core_clk);
        cmd <= '{op: op, bank: bk, auto_precharge: ap, all_banks_select: ab, mrw_reset: mr};
        @(negedge core_clk);
        cmd <= '{op: CMD_NOP, bank: ~bk, auto_precharge: ~ap, all_banks_select: ~ab,
                 mrw_reset: ~mr};
    endtask : send
endmodule : ctrl_model

// ==== dram_bank_state_tracker_bench.sv ====
// Self-checking bench for the bank state tracker.
// Assumes the controller model drives the command port on the falling edge.
`timescale 1ns/1ps
module dram_bank_state_tracker_bench;
    import dram_bank_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cke;
    cmd_s cmd;
    bank_state_e bank_state [NUM_BANKS];
    status_s status;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] lfsr_q = 32'h0000_ac99;
    logic [BANK_W-1:0] b;
    logic ap;
    cmd_op_e op1;
    cmd_op_e op2;

    always #12.5 core_clk = ~core_clk;

    ctrl_model i_ctrl (.core_clk(core_clk), .cke(cke), .cmd(cmd));
    dram_bank_state_tracker i_dut (.core_clk(core_clk), .rst(rst), .cke(cke), .cmd(cmd),
        .bank_state(bank_state), .status(status));

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : lfsr_next

    function automatic bank_state_e st_of(input cmd_op_e op, input logic a);
        if (op == CMD_RD) begin
            return a ? ST_RD_AP : ST_READING;
        end
        return a ? ST_WR_AP : ST_WRITING;
    endfunction : st_of

    task automatic chk_st(input int bk, input bank_state_e exp);
        n_checks++;
        if (bank_state[bk] !== exp) begin
            error_cnt++;
            $display("MISMATCH bank_state[%0d] expected %s seen %s", bk, exp.name(),
                     bank_state[bk].name());
        end
    endtask : chk_st

    task automatic chk_bit(input string nm, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_bit

    // Command taken, state s1 for n cycles on bank cb, then s2
    task automatic run(input cmd_op_e op, input int bk, input logic a, input logic ab,
                       input logic mr, input int cb, input bank_state_e s1, input int n,
                       input bank_state_e s2);
        i_ctrl.send(op, bk[BANK_W-1:0], a, ab, mr);
        chk_bit("cmd_taken", 1'b1, status.cmd_taken);
        chk_st(cb, s1);
        repeat (n - 1) @(negedge core_clk);
        chk_st(cb, s1);
        @(negedge core_clk);
        chk_st(cb, s2);
    endtask : run

    // Refused command leaves the bank as it was
    task automatic bad(input cmd_op_e op, input int bk, input bank_state_e s);
        i_ctrl.send(op, bk[BANK_W-1:0], 1'b0, 1'b0, 1'b0);
        chk_bit("cmd_illegal", 1'b1, status.cmd_illegal);
        chk_bit("cmd_taken", 1'b0, status.cmd_taken);
        chk_st(bk, s);
    endtask : bad

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : results

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            $display("MISMATCH run_time expected finished seen running");
            results();
        end
    end

    initial begin
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        chk_st(0, ST_POWER_ON);
        chk_bit("all_banks_idle", 1'b0, status.all_banks_idle);
        run(CMD_MRW, 0, 0, 0, 1, 3, ST_RESETTING, T_RST_CYC, ST_IDLE);
        chk_bit("all_banks_idle", 1'b1, status.all_banks_idle);
        i_ctrl.send(CMD_MRW, 3'h5, 1'b0, 1'b0, 1'b1);
        chk_st(5, ST_RESETTING);
        run(CMD_MRR, 0, 0, 0, 0, 0, ST_MRR_RESET, T_MRR_CYC, ST_RESETTING);
        for (int i = 0; i < 100 && status.all_banks_idle !== 1'b1; i++) @(negedge core_clk);
        chk_bit("all_banks_idle", 1'b1, status.all_banks_idle);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            lfsr_q = lfsr_next(lfsr_q);
            b = lfsr_q[2:0];
            ap = lfsr_q[8];
            op1 = lfsr_q[9] ? CMD_RD : CMD_WR;
            op2 = lfsr_q[9] ? CMD_WR : CMD_RD;
            run(CMD_ACT, b, 0, 0, 0, b, ST_ACTIVATING, T_RCD_CYC, ST_ACTIVE);
            run(op1, b, 0, 0, 0, b, st_of(op1, 1'b0), BURST_CYC, st_of(op1, 1'b0));
            run(op2, b, ap, 0, 0, b, st_of(op2, ap), ap ? AP_CYC : BURST_CYC,
                ap ? ST_IDLE : st_of(op2, 1'b0));
            if (!ap) begin
                run(CMD_PRE, b, 0, 0, 0, b, ST_PRECHARGING, T_RP_CYC, ST_IDLE);
            end
        end
        $display("test bursts done");
        run(CMD_PRE, b, 0, 0, 0, b, ST_PRECHARGING, T_RP_CYC, ST_IDLE);
        run(CMD_ACT, b, 0, 0, 0, b, ST_ACTIVATING, T_RCD_CYC, ST_ACTIVE);
        run(CMD_ACT, b ^ 1, 0, 0, 0, b ^ 1, ST_ACTIVATING, T_RCD_CYC, ST_ACTIVE);
        lfsr_q = lfsr_next(lfsr_q);
        run(CMD_PRE, lfsr_q[2:0], 0, 1, 0, b ^ 2, ST_PRE_ALL, T_RP_CYC, ST_IDLE);
        chk_st(b, ST_IDLE);
        $display("test precharge done");
        run(CMD_REF_PB, b, 0, 0, 0, b, ST_REF_PB, T_RFCPB_CYC, ST_IDLE);
        run(CMD_REF_AB, b, 0, 0, 0, 7, ST_REF_AB, T_RFCAB_CYC, ST_IDLE);
        run(CMD_MRR, b, 0, 0, 0, b, ST_MRR_IDLE, T_MRR_CYC, ST_IDLE);
        run(CMD_MRW, 0, 0, 0, 0, 2, ST_MR_WRITING, T_MRW_CYC, ST_IDLE);
        $display("test refresh and mode done");
        run(CMD_ACT, b, 0, 0, 0, b, ST_ACTIVATING, T_RCD_CYC, ST_ACTIVE);
        run(CMD_MRR, b, 0, 0, 0, b, ST_MRR_ACTIVE, T_MRR_CYC, ST_ACTIVE);
        bad(CMD_ACT, b, ST_ACTIVE);
        bad(CMD_REF_AB, b, ST_ACTIVE);
        bad(CMD_RD, b ^ 1, ST_IDLE);
        run(CMD_PRE, b, 0, 0, 0, b, ST_PRECHARGING, T_RP_CYC, ST_IDLE);
        $display("test refusal done");
        run(CMD_PRE, 0, 0, 0, 0, 0, ST_PRECHARGING, T_RP_CYC, ST_IDLE);
        run(CMD_ACT, 0, 0, 0, 0, 0, ST_ACTIVATING, T_RCD_CYC, ST_ACTIVE);
        run(CMD_MRR, 0, 0, 0, 0, 0, ST_MRR_ACTIVE, T_MRR_CYC, ST_ACTIVE);
        run(CMD_RD, 0, 0, 0, 0, 0, ST_READING, BURST_CYC, ST_READING);
        i_ctrl.send(CMD_RD, 3'h0, 1'b1, 1'b0, 1'b0);
        bad(CMD_ACT, 0, ST_RD_AP);
        run(CMD_ACT, 1, 0, 0, 0, 1, ST_ACTIVATING, T_RCD_CYC, ST_ACTIVE);
        chk_st(0, ST_IDLE);
        run(CMD_PRE, 1, 0, 0, 0, 1, ST_PRECHARGING, T_RP_CYC, ST_IDLE);
        $display("test auto precharge done");
        i_ctrl.hold_cke(1'b0);
        i_ctrl.send(CMD_ACT, b, 1'b0, 1'b0, 1'b0);
        chk_bit("cmd_taken", 1'b0, status.cmd_taken);
        chk_bit("cmd_illegal", 1'b0, status.cmd_illegal);
        chk_st(b, ST_IDLE);
        i_ctrl.hold_cke(1'b1);
        repeat (3) @(negedge core_clk);
        run(CMD_ACT, b, 0, 0, 0, b, ST_ACTIVATING, T_RCD_CYC, ST_ACTIVE);
        $display("test clock enable done");
        results();
    end
endmodule : dram_bank_state_tracker_bench
